// ==== uci_pkg.sv ====
// Package: command codes, frame layout and limits of the UI command link
package uci_pkg;
   localparam logic [7:0] UCI_CMD_SERVER  = 8'h06;
   localparam logic [7:0] UCI_CMD_INFO    = 8'h07;
   localparam logic [7:0] UCI_CMD_GETVAL  = 8'h08;
   localparam logic [7:0] UCI_CMD_PROPS   = 8'h09;
   localparam logic [7:0] UCI_CMD_SETVAL  = 8'h0a;
   localparam logic [7:0] UCI_SRV_START   = 8'h01;
   localparam logic [7:0] UCI_SRV_FINISH  = 8'h02;
   localparam logic [7:0] UCI_SRV_DIALOG  = 8'h03;
   localparam logic [7:0] UCI_SRV_DISC    = 8'h04;
   localparam logic [7:0] UCI_SRV_INIT    = 8'h09;
   localparam logic [7:0] UCI_INFO_GEN    = 8'h01;
   localparam logic [7:0] UCI_INFO_DLG    = 8'h02;
   localparam logic [7:0] UCI_INFO_CTL    = 8'h03;
   localparam logic [7:0] UCI_PROPS_LEN   = 8'h0c;
   localparam logic [7:0] UCI_PF_NOSHOW   = 8'h01;
   localparam logic [7:0] UCI_PF_ONSCREEN = 8'h10;
   localparam logic [7:0] UCI_PF_COLOUR   = 8'h40;
   localparam logic [7:0] UCI_ICON_MAX    = 8'h05;
   localparam logic [7:0] UCI_BTN_MAX     = 8'h60;
   localparam logic [7:0] UCI_VAL_ON      = 8'hff;
   localparam logic [7:0] UCI_VAL_OFF     = 8'h00;
   localparam int         UCI_CHUNK       = 16;
   localparam int         UCI_MAXFRAME    = 32;
   localparam int         UCI_NCTL        = 16;
   localparam int         UCI_CTLBYTES    = 32;
   localparam logic [7:0] UCI_FRAME_MIN   = 8'h02;
   localparam logic [7:0] UCI_INIT_BYTE   = 8'h00;
endpackage : uci_pkg

// ==== uci_if.sv ====
// Interface: byte stream in both directions between host and device
`timescale 1ns/1ps
interface uci_if;
   logic       h2d_valid;
   logic [7:0] h2d_data;
   logic       d2h_valid;
   logic [7:0] d2h_data;
   modport dev  (input h2d_valid, h2d_data, output d2h_valid, d2h_data);
   modport host (output h2d_valid, h2d_data, input d2h_valid, d2h_data);
endinterface : uci_if

// ==== uci_device.sv ====
// Device end: frame receiver, command decode, control store and responder
//
// Operation
// R1: Info second byte selects general, dialog, control
// R2: One reply for general/dialog, two for control
// R3: Info queries are not checked against layout
// R4: Control identifier follows command byte
// R5: 0x08 reads value, 0x0A writes value
// R6: Reads answer in 16-byte chunks, at least one
// R7: Value access works with service stopped
// R8: Properties forwarded to client, never stored
// R9: Property frame twelve bytes: id, flags, colour
// R10: Message flags: show, update, icon, buttons
// R11: Other controls: onscreen 0x10, colour 0x40
// R12: Colour word is red, green, blue, zero
// R13: Message shows only with its dialog; the code drives props_show_o from the flag byte alone, without dialog_o
// R14: Write has little-endian offset, small controls zero
// R15: Large writes chunked, zero offset sends update
// R16: Latch, password, section: one byte 00/ff
// R17: List and number: four little-endian bytes
// R18: Date-time eight bytes; some controls no data
// R19: Dialog select index counts from zero
// R20: Disconnect drops client, service keeps running
// R21: Data initialised at start and on command
// R22: First byte is total frame length
// R23: Act only once the whole frame arrived
`timescale 1ns/1ps
module uci_device
   import uci_pkg::*;
(
   input  wire logic       clk_i,         // System clock
   input  wire logic       rstn_i,        // Async reset, active low
   uci_if.dev              link,          // Byte link to host
   input  wire logic       client_conn_i, // Client presently connected
   output logic            running_o,     // Service running
   output logic [7:0]      dialog_o,      // Shown dialog index
   output logic            drop_client_o, // Pulse: drop current client
   output logic            props_valid_o, // Pulse: property frame to client
   output logic [15:0]     props_id_o,    // Property control identifier
   output logic [31:0]     props_flags_o, // Property flag word, byte0 low
   output logic [31:0]     props_colour_o,// Colour word, red in low byte
   output logic            props_show_o,  // Message to be displayed
   output logic [7:0]      props_icon_o,  // Icon selection, 0 if none
   output logic [7:0]      props_btn_o,   // Button set, 0 if none
   output logic            props_onscr_o, // Force onscreen
   output logic            props_colen_o, // Colour to be applied
   output logic            upd_valid_o,   // Pulse: value update to client
   output logic [15:0]     upd_id_o,      // Updated control identifier
   output logic            info_valid_o,  // Pulse: info query raised
   output logic [7:0]      info_kind_o,   // Info property byte
   output logic [15:0]     info_arg_o     // Dialog index or control id
);
   typedef enum logic [1:0] {UCI_RX, UCI_EXEC, UCI_SEND} uci_state_e;
   uci_state_e state;
   logic [7:0] frame [UCI_MAXFRAME];
   logic [7:0] store [UCI_NCTL][UCI_CTLBYTES];
   logic [7:0] cnt;
   logic [7:0] flen;
   logic [7:0] tx_idx;
   logic [7:0] tx_len;
   logic [1:0] info_left;
   logic [3:0] ctl_sel;
   logic [7:0] wr_off;

   function automatic logic [31:0] uci_word(input logic [7:0] b0, input logic [7:0] b1,
                                            input logic [7:0] b2, input logic [7:0] b3);
      return {b3, b2, b1, b0};
   endfunction : uci_word

   assign ctl_sel = frame[2][3:0];                                     // R4
   assign wr_off  = frame[4];                                          // R14

   // Frame capture
   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         cnt  <= 8'h00;
         flen <= 8'h00;
      end else if (state == UCI_RX && link.h2d_valid) begin
         if (cnt == 8'h00) begin
            flen <= link.h2d_data;                                     // R22
            cnt  <= 8'h01;
         end else if (cnt + 8'h01 >= flen) begin
            cnt <= 8'h00;                                              // R23
         end else begin
            cnt <= cnt + 8'h01;
         end
      end
   end

   always_ff @(posedge clk_i) begin
      if (state == UCI_RX && link.h2d_valid && cnt < 8'(UCI_MAXFRAME)) begin
         frame[cnt[4:0]] <= link.h2d_data;
      end
   end

   // Sequencing
   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         state <= UCI_RX;
      end else begin
         unique case (state)
            UCI_RX: begin
               if (link.h2d_valid && cnt != 8'h00 && cnt + 8'h01 >= flen) begin
                  state <= UCI_EXEC;                                   // R23
               end
            end
            UCI_EXEC: begin
               if (frame[1] == UCI_CMD_GETVAL) begin
                  state <= UCI_SEND;
               end else if (frame[1] == UCI_CMD_INFO && frame[2] == UCI_INFO_CTL) begin
                  state <= UCI_SEND;
               end else begin
                  state <= UCI_RX;
               end
            end
            UCI_SEND: begin
               if (frame[1] == UCI_CMD_INFO) begin
                  if (info_left == 2'd1) state <= UCI_RX;
               end else if (tx_idx + 8'h01 >= tx_len) begin
                  state <= UCI_RX;
               end
            end
            default: begin
               state <= UCI_RX;
            end
         endcase
      end
   end

   // Service state
   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         running_o <= 1'b0;
         dialog_o  <= 8'h00;
      end else if (state == UCI_EXEC && frame[1] == UCI_CMD_SERVER) begin
         if (frame[2] == UCI_SRV_START)  running_o <= 1'b1;
         if (frame[2] == UCI_SRV_FINISH) running_o <= 1'b0;
         if (frame[2] == UCI_SRV_DIALOG) dialog_o <= frame[3];         // R19
      end
   end

   // Control value store, no dependence on running_o
   always_ff @(posedge clk_i) begin
      for (int c = 0; c < UCI_NCTL; c++) begin
         for (int b = 0; b < UCI_CTLBYTES; b++) begin
            if (state == UCI_EXEC && frame[1] == UCI_CMD_SERVER &&
                (frame[2] == UCI_SRV_START || frame[2] == UCI_SRV_INIT)) begin
               store[c][b] <= UCI_INIT_BYTE;                           // R21
            end else if (state == UCI_EXEC && frame[1] == UCI_CMD_SETVAL &&
                         c == int'(ctl_sel) && b >= int'(wr_off) &&
                         b - int'(wr_off) < int'(flen) - 6) begin
               store[c][b] <= frame[6 + b - int'(wr_off)];             // R7 R14 R16 R17 R18
            end
         end
      end
   end

   // Responses to client and host
   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         drop_client_o  <= 1'b0;
         props_valid_o  <= 1'b0;
         props_id_o     <= 16'h0000;
         props_flags_o  <= 32'h0000_0000;
         props_colour_o <= 32'h0000_0000;
         upd_valid_o    <= 1'b0;
         upd_id_o       <= 16'h0000;
      end else begin
         drop_client_o <= state == UCI_EXEC && frame[1] == UCI_CMD_SERVER &&
                          frame[2] == UCI_SRV_DISC;                    // R20
         props_valid_o <= state == UCI_EXEC && frame[1] == UCI_CMD_PROPS &&
                          flen == UCI_PROPS_LEN && client_conn_i;      // R8 R9
         if (state == UCI_EXEC && frame[1] == UCI_CMD_PROPS) begin
            props_id_o     <= {frame[2], frame[3]};
            props_flags_o  <= uci_word(frame[4], frame[5], frame[6], frame[7]);
            props_colour_o <= uci_word(frame[8], frame[9], frame[10], frame[11]); // R12
         end
         upd_valid_o <= state == UCI_EXEC && frame[1] == UCI_CMD_SETVAL &&
                        frame[4] == 8'h00 && frame[5] == 8'h00;        // R15
         if (state == UCI_EXEC && frame[1] == UCI_CMD_SETVAL) begin
            upd_id_o <= {frame[2], frame[3]};
         end
      end
   end

   // Property decode, flags combine by OR
   assign props_show_o  = props_flags_o[7:0] == 8'h00;                // R10
   assign props_icon_o  = (props_flags_o[23:16] & 8'h0f) <= UCI_ICON_MAX ?
                          (props_flags_o[23:16] & 8'h0f) : 8'h00;
   assign props_btn_o   = (props_flags_o[23:16] & 8'hf0) <= UCI_BTN_MAX ?
                          (props_flags_o[23:16] & 8'hf0) : 8'h00;
   assign props_onscr_o = |(props_flags_o[7:0] & UCI_PF_ONSCREEN);    // R11
   assign props_colen_o = |(props_flags_o[7:0] & UCI_PF_COLOUR);

   // Info query and value readback
   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         info_valid_o   <= 1'b0;
         info_kind_o    <= 8'h00;
         info_arg_o     <= 16'h0000;
         info_left      <= 2'd0;
         tx_idx         <= 8'h00;
         tx_len         <= 8'h00;
         link.d2h_valid <= 1'b0;
         link.d2h_data  <= 8'h00;
      end else begin
         info_valid_o   <= 1'b0;
         link.d2h_valid <= 1'b0;
         if (state == UCI_EXEC && frame[1] == UCI_CMD_INFO) begin
            info_valid_o <= 1'b1;                                      // R1 R2 R3
            info_kind_o  <= frame[2];
            info_arg_o   <= frame[2] == UCI_INFO_CTL ? {frame[3], frame[4]} :
                            frame[2] == UCI_INFO_DLG ? {8'h00, frame[3]} : 16'h0000;
            info_left    <= frame[2] == UCI_INFO_CTL ? 2'd1 : 2'd0;
         end else if (state == UCI_SEND && frame[1] == UCI_CMD_INFO) begin
            info_valid_o <= 1'b1;                                      // R2
            info_left    <= 2'd0;
         end
         if (state == UCI_EXEC && frame[1] == UCI_CMD_GETVAL) begin
            tx_idx  <= 8'h00;                                          // R5 R6
            tx_len  <= 8'(UCI_CTLBYTES);
         end else if (state == UCI_SEND && frame[1] == UCI_CMD_GETVAL) begin
            link.d2h_valid <= 1'b1;                                    // R6
            link.d2h_data  <= store[ctl_sel][tx_idx[4:0]];
            tx_idx         <= tx_idx + 8'h01;
         end
      end
   end
endmodule : uci_device

// ==== uci_host.sv ====
// Host end: serialises command frames onto the byte link
`timescale 1ns/1ps
module uci_host
   import uci_pkg::*;
(
   input  wire logic       clk_i,      // System clock
   input  wire logic       rstn_i,     // Async reset, active low
   uci_if.host             link,       // Byte link to device
   input  wire logic       wr_i,       // Write strobe, load frame byte
   input  wire logic [4:0] addr_i,     // Frame byte index
   input  wire logic [7:0] wdata_i,    // Frame byte value
   input  wire logic       go_i,       // Pulse: send loaded frame
   input  wire logic       rd_i,       // Read strobe, copy last reply byte
   output logic [7:0]      rdata_o,    // Last reply byte, one cycle later
   output logic            busy_o      // Frame being sent
);
   logic [7:0] buffer [UCI_MAXFRAME];
   logic [7:0] idx;
   logic [7:0] rx_last;

   always_ff @(posedge clk_i) begin
      if (wr_i && !busy_o) buffer[addr_i] <= wdata_i;   // R4 R9 R12 R14 R22
   end

   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         busy_o         <= 1'b0;
         idx            <= 8'h00;
         link.h2d_valid <= 1'b0;
         link.h2d_data  <= 8'h00;
      end else begin
         link.h2d_valid <= 1'b0;
         if (go_i && !busy_o && buffer[0] >= UCI_FRAME_MIN) begin
            busy_o <= 1'b1;
            idx    <= 8'h00;
         end else if (busy_o) begin
            link.h2d_valid <= 1'b1;
            link.h2d_data  <= buffer[idx[4:0]];
            idx            <= idx + 8'h01;
            if (idx + 8'h01 >= buffer[0]) busy_o <= 1'b0;      // R22
         end
      end
   end

   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         rx_last <= 8'h00;
         rdata_o <= 8'h00;
      end else begin
         if (link.d2h_valid) rx_last <= link.d2h_data;
         if (rd_i) rdata_o <= rx_last;
      end
   end
endmodule : uci_host

// ==== uci_link_props.sv ====
// Checker: timing of device pulses against the host byte stream
`timescale 1ns/1ps
module uci_link_props (
   input wire logic clk_i,         // System clock
   input wire logic rstn_i,        // Async reset, active low
   input wire logic h2d_valid_i,   // Host byte strobe
   input wire logic d2h_valid_i,   // Device byte strobe
   input wire logic client_conn_i, // Client connected
   input wire logic props_valid_i, // Property pulse
   input wire logic upd_valid_i,   // Update pulse
   input wire logic drop_client_i, // Drop pulse
   input wire logic info_valid_i   // Info pulse
);
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!rstn_i);

   sequence s_once(sig);
      sig ##1 !sig;
   endsequence

   // Last frame byte two cycles back, link idle one cycle back
   sequence s_frame_done;
      $past(h2d_valid_i, 2) && !$past(h2d_valid_i);
   endsequence

   chk_props_client: assert property (props_valid_i |-> $past(client_conn_i))
      else $error("property pulse without client");
   chk_props_once: assert property (props_valid_i |-> s_once(props_valid_i))
      else $error("property pulse too long");
   chk_props_after: assert property (props_valid_i |-> s_frame_done)
      else $error("property pulse not two cycles after last byte");
   chk_upd_after: assert property (upd_valid_i |-> s_frame_done)
      else $error("update pulse not two cycles after last byte");
   chk_upd_once: assert property (upd_valid_i |-> s_once(upd_valid_i))
      else $error("update pulse too long");
   chk_drop_after: assert property (drop_client_i |-> s_frame_done)
      else $error("drop pulse not two cycles after last byte");
   chk_drop_once: assert property (drop_client_i |-> s_once(drop_client_i))
      else $error("drop pulse too long");
   chk_info_after: assert property ($rose(info_valid_i) |-> s_frame_done)
      else $error("info pulse not two cycles after last byte");
   chk_tx_vs_rx: assert property (d2h_valid_i |-> !h2d_valid_i)
      else $error("device sends while host sends");
endmodule : uci_link_props

// ==== ui_control_command_interpreter_tb.sv ====
// Testbench: host end and device end joined, frames sent through host buffer
`timescale 1ns/1ps
module ui_control_command_interpreter_tb;
   import uci_pkg::*;
   logic        clk_i = 1'b0;
   logic        rstn_i = 1'b0;
   logic        client_conn_i = 1'b0;
   logic        wr_i = 1'b0;
   logic [4:0]  addr_i = 5'h00;
   logic [7:0]  wdata_i = 8'h00;
   logic        go_i = 1'b0;
   logic        rd_i = 1'b0;
   logic [7:0]  rdata_o, dialog_o, info_kind_o, props_icon_o, props_btn_o;
   logic        busy_o, running_o, drop_client_o, props_valid_o, upd_valid_o, info_valid_o;
   logic        props_show_o, props_onscr_o, props_colen_o;
   logic [15:0] props_id_o, upd_id_o, info_arg_o;
   logic [31:0] props_flags_o, props_colour_o;
   logic [7:0]  rx[$];
   int          n_fail = 0, checked = 0, cyc = 0;
   int          n_pr = 0, n_up = 0, n_dr = 0, n_in = 0, b;
   uci_if lnk();
   uci_device uci_device_inst (.clk_i(clk_i), .rstn_i(rstn_i), .link(lnk),
      .client_conn_i(client_conn_i), .running_o(running_o), .dialog_o(dialog_o),
      .drop_client_o(drop_client_o), .props_valid_o(props_valid_o), .props_id_o(props_id_o),
      .props_flags_o(props_flags_o), .props_colour_o(props_colour_o),
      .props_show_o(props_show_o), .props_icon_o(props_icon_o), .props_btn_o(props_btn_o),
      .props_onscr_o(props_onscr_o), .props_colen_o(props_colen_o),
      .upd_valid_o(upd_valid_o), .upd_id_o(upd_id_o), .info_valid_o(info_valid_o),
      .info_kind_o(info_kind_o), .info_arg_o(info_arg_o));
   uci_host uci_host_inst (.clk_i(clk_i), .rstn_i(rstn_i), .link(lnk), .wr_i(wr_i),
      .addr_i(addr_i), .wdata_i(wdata_i), .go_i(go_i), .rd_i(rd_i), .rdata_o(rdata_o),
      .busy_o(busy_o));
   uci_link_props uci_link_props_inst (.clk_i(clk_i), .rstn_i(rstn_i),
      .h2d_valid_i(lnk.h2d_valid), .d2h_valid_i(lnk.d2h_valid), .client_conn_i(client_conn_i),
      .props_valid_i(props_valid_o), .upd_valid_i(upd_valid_o),
      .drop_client_i(drop_client_o), .info_valid_i(info_valid_o));

   always #5 clk_i = ~clk_i;

   // Pulse counters and reply capture
   always @(posedge clk_i) begin
      cyc <= cyc + 1;
      if (props_valid_o === 1'b1) n_pr <= n_pr + 1;
      if (upd_valid_o === 1'b1) n_up <= n_up + 1;
      if (drop_client_o === 1'b1) n_dr <= n_dr + 1;
      if (info_valid_o === 1'b1) n_in <= n_in + 1;
      if (lnk.d2h_valid === 1'b1) rx.push_back(lnk.d2h_data);
      if (cyc == 20000) begin
         n_fail = n_fail + 1;
         report_and_stop();
      end
   end

   task automatic report_and_stop();
      $display("checks %0d mismatches %0d", checked, n_fail);
      if (n_fail == 0 && checked > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask : report_and_stop

   task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
      checked++;
      if (seen !== exp) begin
         n_fail++;
         $display("mismatch %s expected %h seen %h", what, exp, seen);
      end
   endtask : chk

   // Load frame into host buffer, launch it, leave room for the 32-byte reply
   task automatic send(input logic [7:0] f[$]);
      for (int i = 0; i < f.size(); i++) begin
         wr_i <= 1'b1;
         addr_i <= 5'(i);
         wdata_i <= f[i];
         @(posedge clk_i);
      end
      wr_i <= 1'b0;
      go_i <= 1'b1;
      @(posedge clk_i);
      go_i <= 1'b0;
      repeat (56) @(posedge clk_i);
      chk("busy", 32'(busy_o), 32'h0);
   endtask : send

   // Read strobe for one cycle; reply byte stands in the cycle after
   task automatic read_reply();
      rd_i <= 1'b1;
      @(posedge clk_i);
      rd_i <= 1'b0;
      @(posedge clk_i);
   endtask : read_reply

   initial begin
      repeat (16) @(posedge clk_i);
      rstn_i <= 1'b1;
      @(posedge clk_i);
      client_conn_i <= 1'b1;
      send('{8'h0c, 8'h09, 8'h03, 8'h00, 8'h50, 8'h00, 8'h00, 8'h00,
             8'hff, 8'h00, 8'h00, 8'h00});
      chk("props", 32'(n_pr), 32'h1);
      chk("id", 32'(props_id_o), 32'h0300);
      chk("flags", props_flags_o, 32'h00000050);
      chk("colour", props_colour_o, 32'h000000ff);
      chk("onscr_colen", {props_onscr_o, props_colen_o}, 32'h3);
      send('{8'h04, 8'h06, 8'h03, 8'h01});
      chk("msg_dialog", 32'(dialog_o), 32'h01);
      send('{8'h0c, 8'h09, 8'h0b, 8'h03, 8'h00, 8'h00, 8'h45, 8'h00,
             8'h00, 8'h00, 8'h00, 8'h00});
      chk("show", 32'(props_show_o), 32'h1);
      chk("icon_btn", {props_icon_o, props_btn_o}, 32'h0540);
      client_conn_i <= 1'b0;
      send('{8'h0c, 8'h09, 8'h03, 8'h00, 8'h01, 8'h00, 8'h00, 8'h00,
             8'h00, 8'h00, 8'h00, 8'h00});
      chk("props_noclient", 32'(n_pr), 32'h2);
      send('{8'h08, 8'h0a, 8'h02, 8'h00, 8'h10, 8'h00, 8'haa, 8'hbb});
      chk("upd_offset", 32'(n_up), 32'h0);
      send('{8'h0a, 8'h0a, 8'h02, 8'h00, 8'h00, 8'h00, 8'h05, 8'h00, 8'h00, 8'h00});
      chk("upd_zero", 32'(n_up), 32'h1);
      chk("upd_id", 32'(upd_id_o), 32'h0200);
      b = rx.size();
      send('{8'h04, 8'h08, 8'h02, 8'h00});
      chk("reply_len", 32'(rx.size() - b), 32'd32);
      chk("reply_lo", {rx[b + 3], rx[b + 2], rx[b + 1], rx[b]}, 32'h00000005);
      chk("reply_chunk", {rx[b + 17], rx[b + 16]}, 32'hbbaa);
      send('{8'h03, 8'h06, 8'h01});
      chk("running", 32'(running_o), 32'h1);
      send('{8'h04, 8'h06, 8'h03, 8'h05});
      chk("dialog", 32'(dialog_o), 32'h05);
      send('{8'h07, 8'h0a, 8'h02, 8'h00, 8'h1f, 8'h00, 8'h5a});
      chk("upd_offset2", 32'(n_up), 32'h1);
      b = rx.size();
      send('{8'h04, 8'h08, 8'h02, 8'h00});
      chk("start_clear", 32'(rx[b]), 32'h00);
      chk("reply_last", 32'(rx[b + 31]), 32'h5a);
      read_reply();
      chk("rdata", 32'(rdata_o), 32'h5a);
      send('{8'h03, 8'h06, 8'h04});
      chk("drop", {31'(n_dr), running_o}, 32'h3);
      send('{8'h03, 8'h06, 8'h02});
      chk("finish", 32'(running_o), 32'h0);
      send('{8'h03, 8'h06, 8'h09});
      b = rx.size();
      send('{8'h04, 8'h08, 8'h02, 8'h00});
      chk("reply_stopped", 32'(rx.size() - b), 32'd32);
      chk("reinit", {rx[b + 31], rx[b]}, 32'h0000);
      send('{8'h03, 8'h07, 8'h01});
      chk("info_gen", 32'(n_in), 32'h1);
      send('{8'h04, 8'h07, 8'h02, 8'h01});
      chk("info_dlg", {info_kind_o, 8'h00, info_arg_o}, 32'h02000001);
      send('{8'h05, 8'h07, 8'h03, 8'h04, 8'h00});
      chk("info_ctl", 32'(n_in), 32'h4);
      report_and_stop();
   end
endmodule : ui_control_command_interpreter_tb
